// >>> rtl/cpp_cam_position_preprocess.sv
// Position preprocessing, scaling and program selection for a cam controller
//
// Decided for this implementation: the placing of the registers and the APB register port.
`default_nettype none
module cpp_cam_position_preprocess
  import cpp_pkg::*;
#(
  parameter int unsigned POS_WIDTH = POS_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire cpp_pkg::cpp_apb_req_t apb_req,
  output cpp_pkg::cpp_apb_rsp_t apb_rsp,
  input wire cpp_pkg::cpp_pins_t pins,
  input wire logic p2p_serial,
  output logic [POS_W-1:0] position,
  output logic [POS_W-1:0] scaled_position,
  output logic [PROG_W-1:0] active_program_marker,
  output logic [PROG_W-1:0] edit_program,
  output logic [3:0] network_device_number,
  output logic value_update,
  output logic warm_start
);
  import cpp_pkg::*;

  typedef struct packed {
    cpp_pins_t s1;
    cpp_pins_t s2;
    logic clr_d;
    logic cnt_d;
    logic incr_mode;
    logic [POS_W-1:0] resol;
    logic [POS_W-1:0] zero_corr;
    logic [POS_W-1:0] preset;
    logic [13:0] speed_scale;
    logic [POS_W-1:0] fict;
    logic [3:0] lang;
    logic [POS_W-1:0] count;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] field;
    logic [PROG_W-1:0] active;
    logic [PROG_W-1:0] edit;
    logic [PROG_W-1:0] prev_edit;
    cpp_menu_t menu;
    cpp_div_t dv;
    logic [47:0] dividend;
    logic [POS_W-1:0] rem;
    logic [47:0] quot;
    logic [5:0] dv_cnt;
    logic [POS_W-1:0] scaled;
    logic [3:0] dev_num;
    logic upd;
    logic warm;
    cpp_apb_rsp_t rsp;
  } cpp_state_t;

  cpp_state_t st_reg;
  cpp_state_t st_next;

  // Wrap a difference into one revolution
  function automatic logic [POS_W-1:0] wrap_sub(input logic [POS_W-1:0] a,
                                                input logic [POS_W-1:0] b,
                                                input logic [POS_W-1:0] m);
    logic [POS_W:0] d;
    d = {1'b0, a} - {1'b0, b};
    if (d[POS_W]) begin
      d = d + {1'b0, m};
    end
    if (d[POS_W-1:0] >= m) begin
      d = d - {1'b0, m};
    end
    return d[POS_W-1:0];
  endfunction

  // Reset defaults of the whole state
  function automatic cpp_state_t defaults();
    cpp_state_t d;
    d = '0;
    d.resol = RESOL_DEF;
    d.preset = PRESET_DEF;
    d.speed_scale = SPEED_DEF;
    d.fict = RESOL_DEF;
    d.lang = LANG_DEF;
    d.menu = CPP_IDLE;
    d.dv = CPP_DV_IDLE;
    return d;
  endfunction

  // Constant reset image so the asynchronous branch loads constants only
  localparam cpp_state_t ST_RESET = defaults();

  logic apb_wr;
  logic apb_rd;
  logic [31:0] wd;
  logic [31:0] rdata;
  logic clr_rise;

  // Next state
  always_comb begin
    logic [POS_W:0] r;
    r = '0;
    st_next = st_reg;
    apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && !st_reg.rsp.pready;
    apb_rd = apb_req.psel && apb_req.penable && !apb_req.pwrite && !st_reg.rsp.pready;
    wd = apb_req.pwdata;
    clr_rise = st_reg.s2.clear && !st_reg.clr_d;
    rdata = 32'h0000_0000;
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    st_next.clr_d = st_reg.s2.clear;
    st_next.cnt_d = st_reg.s2.raw[0];
    st_next.upd = 1'b0;
    st_next.warm = 1'b0;
    st_next.rsp = '0;
    // Device number follows the DIP switch while p2p_serial is low, and is zero while it is high
    st_next.dev_num = p2p_serial ? 4'h0 : st_reg.s2.dev_number;
    // Position source
    if (st_reg.incr_mode) begin
      if (clr_rise) begin
        st_next.count = st_reg.s2.preset_sel ? st_reg.preset : '0;
      end else if (st_reg.s2.raw[0] && !st_reg.cnt_d) begin // Edge seen after the second flop
        st_next.count = (st_reg.count >= st_reg.resol - 24'h000001) ? '0 :
                        st_reg.count + 24'h000001;
      end
      st_next.pos = st_reg.count;
    end else begin
      st_next.pos = wrap_sub(st_reg.s2.raw, st_reg.zero_corr, st_reg.resol);
    end
    // Scaling: pos * fict / resol, rounded up when the remainder is above one half
    case (st_reg.dv)
      CPP_DV_IDLE: begin
        st_next.dividend = 48'(st_reg.pos) * 48'(st_reg.fict);
        st_next.rem = '0;
        st_next.quot = '0;
        st_next.dv_cnt = 6'h30;
        st_next.dv = CPP_DV_RUN;
      end
      CPP_DV_RUN: begin
        r = {st_reg.rem, st_reg.dividend[47]};
        st_next.dividend = {st_reg.dividend[46:0], 1'b0};
        if (r >= {1'b0, st_reg.resol}) begin
          r = r - {1'b0, st_reg.resol};
          st_next.quot = {st_reg.quot[46:0], 1'b1};
        end else begin
          st_next.quot = {st_reg.quot[46:0], 1'b0};
        end
        st_next.rem = r[POS_W-1:0];
        st_next.dv_cnt = st_reg.dv_cnt - 6'h01;
        if (st_reg.dv_cnt == 6'h01) begin
          st_next.dv = CPP_DV_DONE;
        end
      end
      CPP_DV_DONE: begin
        if ({st_reg.rem, 1'b0} > {1'b0, st_reg.resol}) begin
          st_next.scaled = st_reg.quot[POS_W-1:0] + 24'h000001;
        end else begin
          st_next.scaled = st_reg.quot[POS_W-1:0];
        end
        st_next.dv = CPP_DV_IDLE;
      end
      default: st_next.dv = CPP_DV_IDLE;
    endcase
    // APB writes
    if (apb_wr) begin
      case (apb_req.paddr)
        OFS_CTRL: st_next.incr_mode = wd[CTRL_INCR];
        OFS_RESOL: st_next.resol = (wd[POS_W-1:0] == '0) ? st_reg.resol : wd[POS_W-1:0];
        OFS_ZERO: st_next.zero_corr = wd[POS_W-1:0];
        OFS_PRESET: st_next.preset = wd[POS_W-1:0];
        OFS_SPEED: begin
          if (wd[13:0] <= SPEED_MAX && wd[31:14] == '0) begin
            st_next.speed_scale = wd[13:0];
          end
        end
        OFS_FICT: st_next.fict = (wd[POS_W-1:0] == '0) ? st_reg.fict : wd[POS_W-1:0];
        OFS_LANG: begin
          if (wd[3:0] <= LANG_MAX && wd[31:4] == '0) begin
            st_next.lang = wd[3:0];
          end
        end
        OFS_FIELD: st_next.field = wd[POS_W-1:0];
        OFS_PROG: st_next.edit = wd[PROG_W-1:0];
        OFS_KEY: begin
          if (wd[KEY_INC]) begin
            st_next.field = st_reg.field + 24'h000001;
            st_next.upd = 1'b1;
          end else if (wd[KEY_DEC]) begin
            st_next.field = st_reg.field - 24'h000001;
            st_next.upd = 1'b1;
          end else if (wd[KEY_TEACH]) begin
            st_next.field = st_reg.pos;
          end else if (wd[KEY_ZTEACH] && !st_reg.incr_mode) begin
            st_next.zero_corr = st_reg.s2.raw;
          end
          // Menu walk for program switch and general reset
          case (st_reg.menu)
            CPP_IDLE: begin
              if (wd[KEY_PROG]) begin
                st_next.prev_edit = st_reg.edit;
                st_next.menu = CPP_PSEL;
              end else if (wd[KEY_GRST]) begin
                st_next.menu = CPP_GASK;
              end
            end
            CPP_PSEL: begin
              if (wd[KEY_ESC]) begin
                st_next.edit = st_reg.prev_edit;
                st_next.menu = CPP_IDLE;
              end else if (wd[KEY_ENTER]) begin
                st_next.menu = CPP_PASK;
              end
            end
            CPP_PASK: begin
              if (wd[KEY_CONFIRM]) begin
                st_next.active = st_reg.edit;
                st_next.menu = CPP_IDLE;
              end else if (wd[KEY_ESC]) begin
                st_next.edit = st_reg.prev_edit;
                st_next.menu = CPP_IDLE;
              end
            end
            CPP_GASK: begin
              if (wd[KEY_CONFIRM]) begin
                st_next = defaults();
                st_next.warm = 1'b1;
              end else if (wd[KEY_ESC]) begin
                st_next.menu = CPP_IDLE;
              end
            end
            default: st_next.menu = CPP_IDLE;
          endcase
        end
        default: ;
      endcase
    end
    // APB reads
    case (apb_req.paddr)
      OFS_CTRL: rdata = {31'h0, st_reg.incr_mode};
      OFS_RESOL: rdata = {8'h00, st_reg.resol};
      OFS_ZERO: rdata = {8'h00, st_reg.zero_corr};
      OFS_PRESET: rdata = {8'h00, st_reg.preset};
      OFS_SPEED: rdata = {18'h0, st_reg.speed_scale};
      OFS_FICT: rdata = {8'h00, st_reg.fict};
      OFS_LANG: rdata = {28'h0, st_reg.lang};
      OFS_KEY: rdata = 32'h0000_0000;
      OFS_PROG: rdata = {16'h0000, st_reg.active, st_reg.edit};
      OFS_POS: rdata = {8'h00, st_reg.pos};
      OFS_SCALED: rdata = {8'h00, st_reg.scaled};
      OFS_STATUS: rdata = {26'h0, st_reg.dev_num, st_reg.menu};
      OFS_FIELD: rdata = {8'h00, st_reg.field};
      default: rdata = 32'h0000_0000;
    endcase
    if (apb_wr || apb_rd) begin
      st_next.rsp.pready = 1'b1;
      st_next.rsp.prdata = apb_rd ? rdata : 32'h0000_0000;
      st_next.rsp.pslverr = (apb_req.paddr > OFS_FIELD) || (apb_req.paddr[1:0] != 2'b00);
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_RESET;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // Outputs from state flops
  assign apb_rsp = st_reg.rsp;
  assign position = st_reg.pos;
  assign scaled_position = st_reg.scaled;
  assign active_program_marker = st_reg.active;
  assign edit_program = st_reg.edit;
  assign network_device_number = st_reg.dev_num;
  assign value_update = st_reg.upd;
  assign warm_start = st_reg.warm;

  // Assertions
  property p_abs_sub;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && !st_reg.incr_mode && $stable(st_reg.zero_corr) && $stable(st_reg.resol)
      |=> position == wrap_sub($past(st_reg.s2.raw), $past(st_reg.zero_corr),
                               $past(st_reg.resol));
  endproperty
  a_abs_sub: assert property (p_abs_sub) else $error("absolute position wrong");
  property p_range;
    @(posedge mclk) disable iff (!rst_n)
      !st_reg.incr_mode |-> ##1 (!$stable(st_reg.resol) || position < st_reg.resol);
  endproperty
  a_range: assert property (p_range) else $error("position out of range");
  property p_clear;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && st_reg.incr_mode && clr_rise |=> st_reg.count ==
        ($past(st_reg.s2.preset_sel) ? $past(st_reg.preset) : '0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear load wrong");
  property p_speed;
    @(posedge mclk) disable iff (!rst_n) st_reg.speed_scale <= SPEED_MAX;
  endproperty
  a_speed: assert property (p_speed) else $error("speed scale out of range");
  property p_lang;
    @(posedge mclk) disable iff (!rst_n) st_reg.lang <= LANG_MAX;
  endproperty
  a_lang: assert property (p_lang) else $error("language out of range");
  property p_dev;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && p2p_serial |=> network_device_number == 4'h0;
  endproperty
  a_dev: assert property (p_dev) else $error("device number not ignored");
  property p_active;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && !(apb_wr && apb_req.paddr == OFS_KEY) |=> $stable(active_program_marker);
  endproperty
  a_active: assert property (p_active) else $error("active program changed");
  property p_warm;
    @(posedge mclk) disable iff (!rst_n)
      warm_start |-> st_reg.speed_scale == SPEED_DEF && st_reg.preset == PRESET_DEF;
  endproperty
  a_warm: assert property (p_warm) else $error("defaults not restored");
  property p_step;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && apb_wr && apb_req.paddr == OFS_KEY && apb_req.pwdata[KEY_INC] &&
        !apb_req.pwdata[KEY_CONFIRM]
      |=> value_update && st_reg.field == $past(st_reg.field) + 24'h000001;
  endproperty
  a_step: assert property (p_step) else $error("increment key step wrong");
  property p_switch;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && apb_wr && apb_req.paddr == OFS_KEY && apb_req.pwdata[KEY_CONFIRM] &&
        st_reg.menu == CPP_PASK |=> active_program_marker == $past(st_reg.edit);
  endproperty
  a_switch: assert property (p_switch) else $error("program switch wrong");
endmodule : cpp_cam_position_preprocess
`default_nettype wire

// >>> rtl/cpp_pkg.sv
// Package with register map, field widths, defaults and state types for the position block
`default_nettype none
package cpp_pkg;
  localparam int unsigned POS_W = 24;
  localparam int unsigned PROG_W = 8;
  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESOL = 8'h04;
  localparam logic [7:0] OFS_ZERO = 8'h08;
  localparam logic [7:0] OFS_PRESET = 8'h0C;
  localparam logic [7:0] OFS_SPEED = 8'h10;
  localparam logic [7:0] OFS_FICT = 8'h14;
  localparam logic [7:0] OFS_LANG = 8'h18;
  localparam logic [7:0] OFS_KEY = 8'h1C;
  localparam logic [7:0] OFS_PROG = 8'h20;
  localparam logic [7:0] OFS_POS = 8'h24;
  localparam logic [7:0] OFS_SCALED = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_FIELD = 8'h30;
  // CTRL bit positions
  localparam int unsigned CTRL_INCR = 0;
  // KEY register command bits (write one to act)
  localparam int unsigned KEY_INC = 0;
  localparam int unsigned KEY_DEC = 1;
  localparam int unsigned KEY_TEACH = 2;
  localparam int unsigned KEY_ZTEACH = 3;
  localparam int unsigned KEY_PROG = 4;
  localparam int unsigned KEY_ENTER = 5;
  localparam int unsigned KEY_ESC = 6;
  localparam int unsigned KEY_GRST = 7;
  localparam int unsigned KEY_CONFIRM = 8;
  // Reset/default values and the speed and language limits
  localparam logic [POS_W-1:0] RESOL_DEF = 24'h002000;
  localparam logic [POS_W-1:0] PRESET_DEF = 24'h000000;
  localparam logic [13:0] SPEED_DEF = 14'h003C;
  localparam logic [13:0] SPEED_MAX = 14'h270F;
  localparam logic [3:0] LANG_DEF = 4'h0;
  localparam logic [3:0] LANG_MAX = 4'h9;
  typedef enum logic [1:0] {CPP_IDLE, CPP_PSEL, CPP_PASK, CPP_GASK} cpp_menu_t;
  // Divider walk state for fictitious scaling
  typedef enum logic [1:0] {CPP_DV_IDLE, CPP_DV_RUN, CPP_DV_DONE} cpp_div_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cpp_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cpp_apb_rsp_t;
  typedef struct packed {
    logic [POS_W-1:0] raw;
    logic clear;
    logic preset_sel;
    logic [3:0] dev_number;
  } cpp_pins_t;
endpackage : cpp_pkg
`default_nettype wire

// >>> tb/cpp_enc_model.sv
// Shaft encoder and Clear/preset/DIP pin model facing the position block
`default_nettype none
module cpp_enc_model
  import cpp_pkg::*;
(
  input wire logic mclk,
  output cpp_pkg::cpp_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Power-up: preset select open (low), no Clear, DIP switch at zero
  initial pins = '0;
  // Absolute encoder presents a new position
  task automatic put(input logic [POS_W-1:0] v);
    @(posedge mclk);
    pins.raw <= v;
  endtask
  // Incremental count pulses, held long enough for the input synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge mclk);
      pins.raw[0] <= 1'b1;
      repeat (3) @(posedge mclk);
      pins.raw[0] <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
  // One Clear event as a rising edge on the clear line
  task automatic clr();
    @(posedge mclk);
    pins.clear <= 1'b1;
    repeat (3) @(posedge mclk);
    pins.clear <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  // Preset select level and DIP switch setting
  task automatic lvl(input logic ps, input logic [3:0] dev);
    @(posedge mclk);
    pins.preset_sel <= ps;
    pins.dev_number <= dev;
  endtask
endmodule // cpp_enc_model
`default_nettype wire

// >>> tb/tb_cam_position_preprocess.sv
// Self-checking bench for the cam position preprocessing block
`default_nettype none
module tb_cam_position_preprocess
  import cpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic p2p = 1'b0;
  logic ce = 1'b1;
  cpp_apb_req_t req = '0;
  cpp_apb_rsp_t rsp;
  cpp_pins_t pins;
  logic [POS_W-1:0] pos, scl;
  logic [PROG_W-1:0] act, edt;
  logic [3:0] dnum;
  logic upd, warm, er;
  logic [31:0] rd;
  logic [31:0] seed = 32'h46B0;
  int err_total = 0, check_count = 0, cyc = 0, n_upd = 0, n_warm = 0;
  int resol, zero, fict, raw, p;

  cpp_cam_position_preprocess i_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(ce),
    .apb_req(req), .apb_rsp(rsp), .pins(pins), .p2p_serial(p2p), .position(pos),
    .scaled_position(scl), .active_program_marker(act), .edit_program(edt),
    .network_device_number(dnum), .value_update(upd), .warm_start(warm));
  cpp_enc_model i_enc (.mclk(mclk), .pins(pins));

  // Clock of 4 ns
  always #2 mclk = ~mclk;
  // Pulse counters and hang limit
  always @(posedge mclk) begin
    cyc++;
    if (upd === 1'b1) n_upd++;
    if (warm === 1'b1) n_warm++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // APB master: setup, access, hold until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic key(input int unsigned b);
    wr(OFS_KEY, 1 << b);
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Reference scaling: integer result, remainder above one half rounds up
  function automatic int sc(input int v);
    int q = v * fict / resol;
    if (2 * (v * fict % resol) > resol) q++;
    return q;
  endfunction
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    tk(4);
    rst_n <= 1'b1;
    rdc(OFS_RESOL, 32'h2000);
    rdc(OFS_FICT, 32'h2000);
    rdc(OFS_PRESET, 32'h0);
    rdc(OFS_SPEED, 32'h3C);
    rdc(OFS_LANG, 32'h0);
    rdc(8'h34, 32'h0);
    chk(32'(er), 32'h1);
    wr(OFS_SPEED, 32'h270F);
    wr(OFS_SPEED, 32'h2710);
    rdc(OFS_SPEED, 32'h270F);
    wr(OFS_LANG, 32'h9);
    wr(OFS_LANG, 32'hA);
    rdc(OFS_LANG, 32'h9);
    $display("test done: registers");
    resol = 32'h3E8;
    fict = 32'h168;
    wr(OFS_RESOL, resol);
    wr(OFS_FICT, fict);
    for (int i = 0; i < 8; i++) begin
      zero = (i == 0) ? 32'hA : (i == 1) ? 32'h3DE : int'(xs() % resol);
      raw = (i < 2) ? 32'h64 : int'(xs() % resol);
      wr(OFS_ZERO, zero);
      i_enc.put(raw[POS_W-1:0]);
      tk(120);
      p = (raw - zero + resol) % resol;
      chk(32'(pos), p);
      chk(32'(scl), sc(p));
    end
    key(KEY_ZTEACH);
    tk(6);
    chk(32'(pos), 32'h0);
    rdc(OFS_ZERO, raw);
    wr(OFS_ZERO, 32'h0);
    i_enc.put(24'h0FA);
    tk(6);
    key(KEY_TEACH);
    rdc(OFS_FIELD, 32'hFA);
    wr(OFS_FIELD, 32'h7);
    key(KEY_INC);
    rdc(OFS_FIELD, 32'h8);
    key(KEY_DEC);
    key(KEY_DEC);
    rdc(OFS_FIELD, 32'h6);
    chk(n_upd, 32'h3);
    // Clock enable low freezes the synchronisers and the position
    @(posedge mclk);
    ce <= 1'b0;
    i_enc.put(24'h0C8);
    tk(8);
    chk(32'(pos), 32'hFA);
    ce <= 1'b1;
    tk(6);
    chk(32'(pos), 32'hC8);
    $display("test done: absolute");
    wr(OFS_ZERO, 32'h1);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_RESOL, 32'h4);
    i_enc.put(24'h0);
    i_enc.clr();
    chk(32'(pos), 32'h0);
    i_enc.pulse(3);
    chk(32'(pos), 32'h3);
    i_enc.pulse(2);
    chk(32'(pos), 32'h1);
    wr(OFS_PRESET, 32'h2);
    i_enc.lvl(1'b1, 4'h5);
    i_enc.clr();
    chk(32'(pos), 32'h2);
    chk(32'(dnum), 32'h5);
    @(posedge mclk);
    p2p <= 1'b1;
    tk(4);
    chk(32'(dnum), 32'h0);
    $display("test done: incremental");
    wr(OFS_PROG, 32'h3);
    tk(2);
    chk(32'(act), 32'h0);
    key(KEY_PROG);
    key(KEY_ENTER);
    key(KEY_CONFIRM);
    tk(2);
    chk(32'(act), 32'h3);
    key(KEY_PROG);
    wr(OFS_PROG, 32'h9);
    key(KEY_ESC);
    tk(2);
    chk(32'(edt), 32'h3);
    rdc(OFS_STATUS, 32'(CPP_IDLE));
    chk(32'(act), 32'h3);
    wr(OFS_SPEED, 32'h64);
    key(KEY_GRST);
    key(KEY_CONFIRM);
    tk(4);
    chk(n_warm, 32'h1);
    rdc(OFS_SPEED, 32'h3C);
    rdc(OFS_RESOL, 32'h2000);
    $display("test done: program and general reset");
    stop_test();
  end
endmodule // tb_cam_position_preprocess
`default_nettype wire
